/* inc/hwdsr_params.svh */
// Constants for the hardware watchdog with software reset.
// Assumes an 8-bit special-function-register port and a 20 MHz system clock.
// What this block does
// - The watchdog count advances once every timer_prescale+1 system clocks.
// - period_select picks a timeout of 2^(field+14) ticks, from 16K up to 2048K.
// - The timebase is a 7-bit prescaler stage feeding a 21-bit counter; overflow is timeout.
// - Any reset leaves the watchdog disabled, and it stops counting in power-down.
// - An unfed timeout gives a reset pulse of 96 clocks, or 48 in double-speed mode.
// - The reset also drives the reset pin at reset_polarity unless reset_output_disable is set.
// - Writing 1EH then E1H to the key register enables the watchdog.
// - watchdog_enabled_flag reads 1 while enabled and 0 after any reset until re-enabled.
// - Register reads between the two key bytes are harmless; any other write breaks the pair.
// - A wrong enable or feed sequence produces an immediate watchdog reset.
// - Writing 5AH then A5H gives a software reset even when disabled and sets the soft flag.
// - Any other key sequence resets at once and sets both the soft and the overflow flag.
// - A software reset is as long as a timeout reset and also drives the pin unless disabled.
// - Hardware sets the overflow flag on a timeout reset and only software or reset_i clears the flags.
// - The key register is write-only and reads back as zero.
`ifndef HWDSR_PARAMS_SVH
`define HWDSR_PARAMS_SVH

// Register offsets
`define HWDSR_KEY_ADDR 8'hA6
`define HWDSR_STATUS_ADDR 8'hA7

// Status register fields
`define HWDSR_BIT_OVF 7
`define HWDSR_BIT_SOFTWARE_RESET_FLAG 6
`define HWDSR_BIT_EN 5
`define HWDSR_BIT_IDLE 4
`define HWDSR_BIT_DISRO 3
`define HWDSR_PS_MSB 2
`define HWDSR_CTL_RESET 5'h00

// Key bytes
`define HWDSR_KEY_WD1 8'h1E
`define HWDSR_KEY_WD2 8'hE1
`define HWDSR_KEY_SW1 8'h5A
`define HWDSR_KEY_SW2 8'hA5

// Timing counts
`define HWDSR_CNT_W 21
`define HWDSR_BASE_BITS 14
`define HWDSR_PULSE_NORMAL 7'h60
`define HWDSR_PULSE_DOUBLE 7'h30

`endif

/* inc/hwdsr_pkg.sv */
// Types shared by the watchdog files.
// Assumes hwdsr_params.svh is compiled alongside.
package hwdsr_pkg;

  // Key sequence tracker
  typedef enum logic [1:0] {
    HWDSR_KEY_IDLE = 2'b00,
    HWDSR_KEY_WD = 2'b01,
    HWDSR_KEY_SW = 2'b10
  } hwdsr_key_t;

  // One register-port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hwdsr_sfr_req_t;

  // Software-written configuration
  typedef struct packed {
    logic idle_halt_bit;
    logic reset_output_disable;
    logic [2:0] period_select;
  } hwdsr_ctl_t;

endpackage

/* hw/hwdsr_prescaler.sv */
// Tick divider ahead of the watchdog counter.
// Assumes the limit input is steady between clears.
`timescale 1ns/10ps
module hwdsr_prescaler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [6:0] limit_i,
  // Tick out
  output logic tick_o
);

  logic [6:0] div_r;

  // One tick per limit+1 running clocks
  always_ff @(posedge clk_i)
  begin
    if (reset_i || (ce_i && clear_i))
    begin
      div_r <= 7'h00;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tick_o <= run_i && (div_r == limit_i);
      if (run_i)
        div_r <= (div_r == limit_i) ? 7'h00 : 7'(div_r + 7'h01);
    end
  end

endmodule

/* hw/hwdsr_top.sv */
// Hardware watchdog with key-register feeding and software reset.
// Assumes reset_i is the device reset and is not fed back from sys_reset_o,
// so the cause flags survive the pulse this block raises.
`timescale 1ns/10ps
`include "hwdsr_params.svh"
module hwdsr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Register port
  input wire hwdsr_pkg::hwdsr_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // Device state
  input wire logic [6:0] timer_prescale_i,
  input wire logic power_down_i,
  input wire logic idle_i,
  input wire logic double_speed_clock_i,
  input wire logic reset_polarity_i,
  // Reset outputs
  output logic sys_reset_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o
);

  hwdsr_pkg::hwdsr_key_t key_r;
  hwdsr_pkg::hwdsr_key_t key_nxt;
  hwdsr_pkg::hwdsr_ctl_t ctl_r;
  logic [`HWDSR_CNT_W-1:0] cnt_r;
  logic [`HWDSR_CNT_W-1:0] limit;
  logic [6:0] pulse_r;
  logic enabled_r;
  logic ovf_r;
  logic software_reset_flag_r;
  logic key_wr;
  logic other_wr;
  logic enable_evt;
  logic sw_evt;
  logic bad_evt;
  logic timeout_evt;
  logic fire;
  logic run;
  logic tick;
  logic stat_wr;

  // Access decode
  assign key_wr = sfr_req_i.wr && (sfr_req_i.addr == `HWDSR_KEY_ADDR);
  assign other_wr = sfr_req_i.wr && (sfr_req_i.addr != `HWDSR_KEY_ADDR);
  assign stat_wr = sfr_req_i.wr && (sfr_req_i.addr == `HWDSR_STATUS_ADDR);

  // Key sequence decode; reads never disturb it, foreign writes do
  always_comb
  begin
    key_nxt = key_r;
    enable_evt = 1'b0;
    sw_evt = 1'b0;
    bad_evt = 1'b0;
    case (key_r)
      hwdsr_pkg::HWDSR_KEY_IDLE:
      begin
        if (key_wr && sfr_req_i.wdata == `HWDSR_KEY_WD1)
          key_nxt = hwdsr_pkg::HWDSR_KEY_WD;
        else if (key_wr && sfr_req_i.wdata == `HWDSR_KEY_SW1)
          key_nxt = hwdsr_pkg::HWDSR_KEY_SW;
        else if (key_wr)
          bad_evt = 1'b1;
      end
      hwdsr_pkg::HWDSR_KEY_WD:
      begin
        if (key_wr || other_wr)
          key_nxt = hwdsr_pkg::HWDSR_KEY_IDLE;
        enable_evt = key_wr && sfr_req_i.wdata == `HWDSR_KEY_WD2;
        bad_evt = other_wr || (key_wr && sfr_req_i.wdata != `HWDSR_KEY_WD2);
      end
      hwdsr_pkg::HWDSR_KEY_SW:
      begin
        if (key_wr || other_wr)
          key_nxt = hwdsr_pkg::HWDSR_KEY_IDLE;
        sw_evt = key_wr && sfr_req_i.wdata == `HWDSR_KEY_SW2;
        bad_evt = other_wr || (key_wr && sfr_req_i.wdata != `HWDSR_KEY_SW2);
      end
      default:
        key_nxt = hwdsr_pkg::HWDSR_KEY_IDLE;
    endcase
  end

  // Selected period: 2^(14+ps) ticks counted in the 21-bit counter
  assign limit = `HWDSR_CNT_W'((`HWDSR_CNT_W'(1) << (`HWDSR_BASE_BITS + ctl_r.period_select)) - 1);
  // Halted in power-down, optionally in idle, and while a pulse runs
  assign run = enabled_r && !power_down_i && !(idle_i && ctl_r.idle_halt_bit) && (pulse_r == 0);
  assign timeout_evt = run && tick && (cnt_r == limit);
  // Events are ignored while a pulse is already out
  assign fire = (pulse_r == 0) && (timeout_evt || sw_evt || bad_evt);

  hwdsr_prescaler u_prescaler (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .run_i(run),
    .clear_i(enable_evt || fire),
    .limit_i(timer_prescale_i),
    .tick_o(tick)
  );

  // Key tracker state, cleared by the pulse
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      key_r <= hwdsr_pkg::HWDSR_KEY_IDLE;
    else if (ce_i)
      key_r <= (pulse_r != 0) ? hwdsr_pkg::HWDSR_KEY_IDLE : key_nxt;
  end

  // Enable flag; any reset, ours included, disables
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      enabled_r <= 1'b0;
    else if (ce_i)
    begin
      if (fire)
        enabled_r <= 1'b0;
      else if (enable_evt && pulse_r == 0)
        enabled_r <= 1'b1;
    end
  end

  // Tick counter, restarted by a feed
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_r <= '0;
    else if (ce_i)
    begin
      if (enable_evt || fire)
        cnt_r <= '0;
      else if (run && tick)
        cnt_r <= `HWDSR_CNT_W'(cnt_r + 1'b1);
    end
  end

  // Configuration bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ctl_r <= `HWDSR_CTL_RESET;
    else if (ce_i && stat_wr)
      ctl_r <= sfr_req_i.wdata[`HWDSR_BIT_IDLE:0];
  end

  // Cause flags: set wins over a software clear; writing 0 clears
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ovf_r <= 1'b0;
      software_reset_flag_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (fire && (timeout_evt || bad_evt))
        ovf_r <= 1'b1;
      else if (stat_wr && !sfr_req_i.wdata[`HWDSR_BIT_OVF])
        ovf_r <= 1'b0;
      if (fire && (sw_evt || bad_evt))
        software_reset_flag_r <= 1'b1;
      else if (stat_wr && !sfr_req_i.wdata[`HWDSR_BIT_SOFTWARE_RESET_FLAG])
        software_reset_flag_r <= 1'b0;
    end
  end

  // Pulse length fixed by clock mode; same for every cause
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      pulse_r <= 7'h00;
    else if (ce_i)
    begin
      if (fire)
        pulse_r <= double_speed_clock_i ? `HWDSR_PULSE_DOUBLE : `HWDSR_PULSE_NORMAL;
      else if (pulse_r != 0)
        pulse_r <= 7'(pulse_r - 7'h01);
    end
  end

  // Reset outputs; pin is input-only when disabled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sys_reset_o <= 1'b0;
      rst_pin_oe_o <= 1'b0;
      rst_pin_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sys_reset_o <= fire || (pulse_r > 7'h01);
      rst_pin_oe_o <= (fire || (pulse_r > 7'h01)) && !ctl_r.reset_output_disable;
      rst_pin_o <= reset_polarity_i;
    end
  end

  // Read data; key register reads as zero
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      sfr_rdata_o <= 8'h00;
    else if (ce_i && sfr_req_i.rd)
      sfr_rdata_o <= (sfr_req_i.addr == `HWDSR_STATUS_ADDR) ?
                     {ovf_r, software_reset_flag_r, enabled_r, ctl_r} : 8'h00;
  end

  // Helper: pulse length seen at the outputs
  logic [6:0] seen_r;
  logic [6:0] want_r;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      seen_r <= 7'h00;
      want_r <= 7'h00;
    end
    else if (ce_i)
    begin
      if (fire)
        want_r <= double_speed_clock_i ? `HWDSR_PULSE_DOUBLE : `HWDSR_PULSE_NORMAL;
      seen_r <= sys_reset_o ? 7'(seen_r + 7'h01) : 7'h00;
    end
  end

  a_pulse_length: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(sys_reset_o) |-> seen_r == want_r)
    else $error("reset pulse length wrong");
  a_timeout_resets: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && timeout_evt && pulse_r == 0) |=> (ovf_r && sys_reset_o && !enabled_r))
    else $error("timeout did not reset and flag");
  a_bad_key_flags: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && bad_evt && pulse_r == 0) |=> (ovf_r && software_reset_flag_r && sys_reset_o))
    else $error("bad key did not set both flags");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && sw_evt && pulse_r == 0 && !ovf_r) |=> (software_reset_flag_r && !ovf_r && sys_reset_o))
    else $error("software reset wrong");
  a_enable_seq: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && enable_evt && !fire) |=> (enabled_r && cnt_r == 0))
    else $error("enable sequence not honoured");
  a_pin_disable: assert property (@(posedge clk_i) disable iff (reset_i)
    rst_pin_oe_o |-> (sys_reset_o && !$past(ctl_r.reset_output_disable)))
    else $error("pin driven when disabled");
  a_pulse_disables: assert property (@(posedge clk_i) disable iff (reset_i)
    sys_reset_o |-> !enabled_r)
    else $error("watchdog enabled during reset");
  a_powerdown_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && power_down_i && !enable_evt && !fire) |=> $stable(cnt_r))
    else $error("counted in power-down");
  a_key_reads_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && sfr_req_i.rd && sfr_req_i.addr == `HWDSR_KEY_ADDR) |=> sfr_rdata_o == 8'h00)
    else $error("key register readable");
  a_read_keeps_seq: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && key_r == hwdsr_pkg::HWDSR_KEY_WD && !sfr_req_i.wr && pulse_r == 0)
    |=> key_r == hwdsr_pkg::HWDSR_KEY_WD)
    else $error("read broke key sequence");

  c_enable: cover property (@(posedge clk_i) disable iff (reset_i) ce_i && enable_evt);
  c_timeout: cover property (@(posedge clk_i) disable iff (reset_i) ce_i && timeout_evt);
  c_soft: cover property (@(posedge clk_i) disable iff (reset_i) ce_i && sw_evt);
  c_bad: cover property (@(posedge clk_i) disable iff (reset_i) ce_i && bad_evt);

endmodule

/* tb/hwdsr_tb.sv */
// Self-checking bench for the hardware watchdog with software reset.
// Assumes hwdsr_pkg is compiled first; ce_i is tied high and power_down_i is tied inactive.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  hwdsr_pkg::hwdsr_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic [6:0] timer_prescale = 7'h00;
  logic dsc = 1'b0;
  logic reset_polarity = 1'b1;
  logic idle = 1'b0;
  logic sys_rst;
  logic pin;
  logic pin_oe;
  logic [7:0] d;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  hwdsr_top i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .timer_prescale_i(timer_prescale), .power_down_i(1'b0), .idle_i(idle),
    .double_speed_clock_i(dsc), .reset_polarity_i(reset_polarity),
    .sys_reset_o(sys_rst), .rst_pin_o(pin), .rst_pin_oe_o(pin_oe)
  );

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  // Hang guard: the timeout test alone needs about 53k cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One-cycle write strobe, as the register port expects
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i) req <= {1'b1, 1'b0, a, v};
    @(posedge clk_i) req <= '0;
  endtask

  // Read data lands on the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i) req <= '0;
    #1 v = rdata;
  endtask

  // Waits for a reset pulse, checks the pin drive and measures its length
  task automatic pulse(input int len, input logic oe, input string msg);
    int w;
    int k;
    w = 0;
    k = 0;
    // Let the launching edge settle so its first pulse cycle is counted
    #1;
    while (sys_rst !== 1'b1 && w < 8)
    begin
      @(posedge clk_i);
      #1 w++;
    end
    while (sys_rst === 1'b1 && k < 200)
    begin
      if (k == 3)
      begin
        `CHK(pin_oe, oe, msg)
        `CHK(pin, reset_polarity, msg)
      end
      @(posedge clk_i);
      #1 k++;
    end
    `CHK(k, len, msg)
  endtask

  task automatic t_reset_state();
    rd(8'hA7, d);
    `CHK(d, 8'h00, "status after reset")
    rd(8'hA6, d);
    `CHK(d, 8'h00, "key register readback")
    `CHK(sys_rst, 1'b0, "reset pulse idle")
    $display("t_reset_state done");
  endtask

  task automatic t_enable_config();
    wr(8'hA6, 8'h1E);
    rd(8'hA7, d);
    wr(8'hA6, 8'hE1);
    rd(8'hA7, d);
    `CHK(d, 8'h20, "enabled flag after key pair")
    wr(8'hA7, 8'hFD);
    rd(8'hA7, d);
    `CHK(d, 8'h3D, "config written, flags untouched")
    wr(8'hA7, 8'h00);
    $display("t_enable_config done");
  endtask

  task automatic t_broken_pair();
    wr(8'hA6, 8'h1E);
    wr(8'hA7, 8'h00);
    pulse(96, 1'b1, "write between key bytes");
    rd(8'hA7, d);
    `CHK(d, 8'hC0, "both flags, watchdog off")
    wr(8'hA6, 8'h33);
    pulse(96, 1'b1, "bad first key byte");
    rd(8'hA7, d);
    `CHK(d, 8'hC0, "flags kept across a second reset")
    wr(8'hA7, 8'h00);
    rd(8'hA7, d);
    `CHK(d, 8'h00, "flags cleared by software")
    $display("t_broken_pair done");
  endtask

  task automatic t_soft_reset();
    dsc <= 1'b1;
    wr(8'hA7, 8'h08);
    wr(8'hA6, 8'h5A);
    wr(8'hA6, 8'hA5);
    pulse(48, 1'b0, "soft reset, double speed, pin off");
    rd(8'hA7, d);
    `CHK(d, 8'h48, "soft flag only")
    dsc <= 1'b0;
    wr(8'hA7, 8'h00);
    $display("t_soft_reset done");
  endtask

  task automatic t_device_reset();
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'hE1);
    @(posedge clk_i) reset_i <= 1'b1;
    @(posedge clk_i) reset_i <= 1'b0;
    rd(8'hA7, d);
    `CHK(d, 8'h00, "device reset disables watchdog")
    $display("t_device_reset done");
  endtask

  // Prescale 1, period code 0: timeout after 16K ticks of 2 clocks
  task automatic t_timeout();
    timer_prescale <= 7'h01;
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'hE1);
    repeat (20000) @(posedge clk_i);
    wr(8'hA6, 8'h1E);
    wr(8'hA6, 8'hE1);
    n = 0;
    while (sys_rst !== 1'b1 && n < 33000)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    `CHK(n > 32740 && n < 32800, 1'b1, "timeout after feed")
    pulse(96, 1'b1, "timeout pulse");
    rd(8'hA7, d);
    `CHK(d, 8'h80, "overflow flag only")
    $display("t_timeout done");
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset_state();
    t_enable_config();
    t_broken_pair();
    t_soft_reset();
    t_device_reset();
    t_timeout();
    stop_test();
  end
endmodule
